// File: logic/ufc_pkg.sv
// Purpose: shared constants of the uart fifo control block
// Assumes: 32-bit classic wishbone, word index = byte address / 4
// Notes:   offsets are word indices, the byte address is four times them
`default_nettype none
package ufc_pkg;
    ////////////////////////////////////////////////////////////////////////
    // register word indices
    localparam logic [5:0] UFC_IDX_DATA   = 6'h00;
    localparam logic [5:0] UFC_IDX_FCR    = 6'h02;
    localparam logic [5:0] UFC_IDX_STATUS = 6'h03;
    localparam logic [5:0] UFC_IDX_MASK   = 6'h04;
    localparam logic [5:0] UFC_IDX_STATE  = 6'h05;
    ////////////////////////////////////////////////////////////////////////
    // fifo_control_reg fields
    localparam int UFC_FCR_EN    = 0;
    localparam int UFC_FCR_RXCLR = 1;
    localparam int UFC_FCR_TXCLR = 2;
    localparam int UFC_FCR_DMA   = 3;
    localparam int UFC_FCR_TRG   = 4;
    localparam logic [7:0] UFC_FCR_RESET = 8'h00;
    ////////////////////////////////////////////////////////////////////////
    // transmit empty-space thresholds, selected by bits 5:4
    localparam logic [7:0] UFC_TXTHR_0 = 8'h08;
    localparam logic [7:0] UFC_TXTHR_1 = 8'h10;
    localparam logic [7:0] UFC_TXTHR_2 = 8'h20;
    localparam logic [7:0] UFC_TXTHR_3 = 8'h38;
    localparam int UFC_BIG_DEPTH = 64;
    ////////////////////////////////////////////////////////////////////////
    // interrupt status bits
    localparam int UFC_IRQ_TXSPACE = 0;
    localparam int UFC_IRQ_RXREQ   = 1;
    localparam int UFC_IRQ_RXOVR   = 2;
    localparam int UFC_IRQ_W       = 3;
endpackage
`default_nettype wire

// File: logic/ufc_fifo_if.sv
// Purpose: link between the control logic and one fifo store
// Assumes: one clock, all signals synchronous
// Notes:   cap limits the usable depth, 1 gives a holding register
`default_nettype none
interface ufc_fifo_if #(
    parameter int W     = 8,
    parameter int DEPTH = 64
);
    localparam int CW = $clog2(DEPTH + 1);
    logic          push;
    logic          pop;
    logic          clear;
    logic [W-1:0]  wdata;
    logic [W-1:0]  rdata;
    logic [CW-1:0] cap;
    logic [CW-1:0] count;
    logic          full;
    logic          empty;
    modport owner (output push, pop, clear, wdata, cap,
                   input rdata, count, full, empty);
    modport store (input push, pop, clear, wdata, cap,
                   output rdata, count, full, empty);
endinterface
`default_nettype wire

// File: logic/ufc_fifo.sv
// Purpose: circular byte store with pointers and occupancy count
// Assumes: DEPTH is a power of two
// Notes:   clear drops pointers and count only, the array keeps stale data
`default_nettype none
module ufc_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 64
) (
    input  wire logic clk_i,      // system clock
    input  wire logic rst_i,      // synchronous reset, active high
    ufc_fifo_if.store f           // control side
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0]  mem [DEPTH];
    logic [PW-1:0] wr_ptr_reg;
    logic [PW-1:0] rd_ptr_reg;
    logic [CW-1:0] count_reg;
    logic          do_push;
    logic          do_pop;

    assign f.full  = (count_reg >= f.cap);
    assign f.empty = (count_reg == '0);
    assign f.count = count_reg;
    assign f.rdata = mem[rd_ptr_reg];
    assign do_push = f.push && !f.full;
    assign do_pop  = f.pop && !f.empty;

    always_ff @(posedge clk_i) begin
        if (do_push) begin
            mem[wr_ptr_reg] <= f.wdata;
        end
    end

    // clear beats any push or pop in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i || f.clear) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_reg <= wr_ptr_reg + PW'(1);
            end
            if (do_pop) begin
                rd_ptr_reg <= rd_ptr_reg + PW'(1);
            end
            if (do_push && !do_pop) begin
                count_reg <= count_reg + CW'(1);
            end else if (do_pop && !do_push) begin
                count_reg <= count_reg - CW'(1);
            end
        end
    end
endmodule
`default_nettype wire

// File: logic/ufc_top.sv
// Purpose: fifo control of one uart channel with dma request pins
// Assumes: classic wishbone slave, 32-bit data, one clock at 100 MHz
// Notes:   dma requests are active low; irq_o is a level
//
// Register access over Wishbone was left to the implementer.
`default_nettype none
// Behaviour
// - transmit threshold field exists only with 64-byte fifos
// - space above threshold raises transmit interrupt, and transmit request in block mode
// - bits 5:4 select threshold 8, 16, 32 or 56; default 8
// - on 16-byte build bits 5:4 are ignored
// - bit 3 set selects block dma mode, only with fifos on
// - bit 3 clear selects single dma mode, the reset default
// - writing 1 to bit 2 empties transmit fifo, self clearing
// - transmit fifo clear leaves transmit shift register alone
// - writing 1 to bit 1 empties receive fifo, self clearing
// - receive fifo clear leaves receive shift register alone
// - other control bits are taken only while bit 0 is written set
// - bit 0 clear disables both fifos; disabled after reset
// - single mode: receive request low while a character is held
// - single mode: transmit request low while transmit store is empty
// - block mode: receive request at trigger or timeout, until empty
// - block mode: transmit request stays low until fifo is full
module ufc_top
    import ufc_pkg::*;
#(
    parameter int DEPTH = 64
) (
    input  wire logic        clk_i,              // system clock
    input  wire logic        rst_i,              // master reset pin, sync
    input  wire logic        wb_cyc_i,           // wishbone cycle
    input  wire logic        wb_stb_i,           // wishbone strobe
    input  wire logic        wb_we_i,            // wishbone write
    input  wire logic [7:0]  wb_adr_i,           // byte address
    input  wire logic [3:0]  wb_sel_i,           // byte lanes
    input  wire logic [31:0] wb_dat_i,           // write data
    output logic      [31:0] wb_dat_o,           // read data
    output logic             wb_ack_o,           // acknowledge
    input  wire logic        tx_shift_done_i,    // serializer took the byte
    output logic      [7:0]  tx_shift_data_o,    // transmit shift register
    output logic             tx_shift_valid_o,   // shift register loaded
    input  wire logic        rx_char_valid_i,    // character assembled
    input  wire logic [7:0]  rx_char_i,          // assembled character
    input  wire logic        rx_timeout_i,       // receive timeout pulse
    input  wire logic [6:0]  rx_trigger_level_i, // receive trigger count
    output logic             tx_dma_request_n_o, // transmit dma request
    output logic             rx_dma_request_n_o, // receive dma request
    output logic             irq_o               // interrupt level
);
    localparam int  CW      = $clog2(DEPTH + 1);
    localparam bit  HAS_THR = (DEPTH == UFC_BIG_DEPTH);

    ////////////////////////////////////////////////////////////////////////
    // fifo stores
    ufc_fifo_if #(.W(8), .DEPTH(DEPTH)) txf ();
    ufc_fifo_if #(.W(8), .DEPTH(DEPTH)) rxf ();

    ufc_fifo #(.W(8), .DEPTH(DEPTH)) u_tx_fifo (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .f     (txf)
    );
    ufc_fifo #(.W(8), .DEPTH(DEPTH)) u_rx_fifo (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .f     (rxf)
    );

    logic [7:0]           fifo_control_reg;
    logic [UFC_IRQ_W-1:0] status_reg;
    logic [UFC_IRQ_W-1:0] mask_reg;
    logic [UFC_IRQ_W-1:0] status_set;
    logic [7:0]           tx_shift_reg;
    logic                 tx_shift_full_reg;
    logic [7:0]           rx_shift_reg;
    logic                 rx_shift_full_reg;
    logic                 tx_active_reg;
    logic                 tx_active_next;
    logic                 rx_active_reg;
    logic                 rx_active_next;
    logic                 tx_level_reg;
    logic                 rx_req_reg;
    logic                 taken;
    logic                 wr;
    logic                 rd;
    logic [5:0]           idx;
    logic                 fifo_en;
    logic                 dma1_eff;
    logic                 thr_en;
    logic [CW-1:0]        tx_space;
    logic [7:0]           tx_thr;
    logic                 tx_level_ok;
    logic                 rx_level_ok;
    logic                 tx_clr;
    logic                 rx_clr;
    logic                 tx_load;
    logic [31:0]          rd_value;

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr    = taken && wb_we_i;
    assign rd    = taken && !wb_we_i;
    assign idx   = wb_adr_i[7:2];

    assign fifo_en  = fifo_control_reg[UFC_FCR_EN];
    // block mode needs fifos on; otherwise single mode applies
    assign dma1_eff = fifo_en && fifo_control_reg[UFC_FCR_DMA];
    assign thr_en   = HAS_THR && fifo_en;

    // clears act only when the same write keeps bit 0 set
    assign tx_clr = wr && idx == UFC_IDX_FCR && wb_sel_i[0]
                    && wb_dat_i[UFC_FCR_EN]
                    && wb_dat_i[UFC_FCR_TXCLR];
    assign rx_clr = wr && idx == UFC_IDX_FCR && wb_sel_i[0]
                    && wb_dat_i[UFC_FCR_EN]
                    && wb_dat_i[UFC_FCR_RXCLR];

    // control register; clear bits are never stored, so they self clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fifo_control_reg <= UFC_FCR_RESET;
        end else if (wr && idx == UFC_IDX_FCR && wb_sel_i[0]) begin
            fifo_control_reg[UFC_FCR_EN] <= wb_dat_i[UFC_FCR_EN];
            if (wb_dat_i[UFC_FCR_EN]) begin
                fifo_control_reg[UFC_FCR_DMA] <= wb_dat_i[UFC_FCR_DMA];
                fifo_control_reg[7:6] <= wb_dat_i[7:6];
                if (HAS_THR) begin
                    fifo_control_reg[5:4] <= wb_dat_i[5:4];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit side
    always_comb begin
        unique case (fifo_control_reg[5:4])
            2'b11:   tx_thr = UFC_TXTHR_3;
            2'b10:   tx_thr = UFC_TXTHR_2;
            2'b01:   tx_thr = UFC_TXTHR_1;
            default: tx_thr = UFC_TXTHR_0;
        endcase
    end

    // disabled fifos shrink to a single holding byte
    assign txf.cap   = fifo_en ? CW'(DEPTH) : CW'(1);
    assign rxf.cap   = fifo_en ? CW'(DEPTH) : CW'(1);
    assign tx_space  = txf.cap - txf.count;
    assign tx_level_ok = thr_en ? (8'(tx_space) > tx_thr)
                                : txf.empty;
    assign txf.push  = wr && idx == UFC_IDX_DATA && wb_sel_i[0];
    assign txf.wdata = wb_dat_i[7:0];
    assign txf.clear = tx_clr;
    assign tx_load   = (!tx_shift_full_reg || tx_shift_done_i) && !txf.empty
                       && !tx_clr;
    assign txf.pop   = tx_load;

    // only the master reset or the serializer finishing empties the shift register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_shift_reg      <= 8'h00;
            tx_shift_full_reg <= 1'b0;
        end else if (tx_load) begin
            tx_shift_reg      <= txf.rdata;
            tx_shift_full_reg <= 1'b1;
        end else if (tx_shift_done_i) begin
            tx_shift_full_reg <= 1'b0;
        end
    end

    // block mode holds the request until the fifo is full
    always_comb begin
        tx_active_next = 1'b0;
        if (dma1_eff) begin
            tx_active_next = (tx_active_reg && !txf.full)
                             || tx_level_ok;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_active_reg      <= 1'b0;
            tx_dma_request_n_o <= 1'b0;
            tx_level_reg       <= 1'b0;
        end else begin
            tx_active_reg <= tx_active_next;
            tx_level_reg  <= tx_level_ok;
            if (dma1_eff) begin
                tx_dma_request_n_o <= !tx_active_next;
            end else begin
                tx_dma_request_n_o <= !txf.empty;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receive side
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_shift_reg      <= 8'h00;
            rx_shift_full_reg <= 1'b0;
        end else if (rx_char_valid_i) begin
            rx_shift_reg      <= rx_char_i;
            rx_shift_full_reg <= 1'b1;
        end else if (!rx_clr) begin
            // a clear blocks the push; keep the character pending instead
            rx_shift_full_reg <= 1'b0;
        end
    end

    // a character that meets a full store is dropped and flagged
    assign rxf.push  = rx_shift_full_reg && !rx_clr;
    assign rxf.wdata = rx_shift_reg;
    assign rxf.clear = rx_clr;
    assign rxf.pop   = rd && idx == UFC_IDX_DATA;
    assign rx_level_ok = (rxf.count >= CW'(rx_trigger_level_i))
                         || rx_timeout_i;

    always_comb begin
        rx_active_next = 1'b0;
        if (dma1_eff) begin
            rx_active_next = !rxf.empty
                             && (rx_active_reg || rx_level_ok);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_active_reg      <= 1'b0;
            rx_dma_request_n_o <= 1'b1;
            rx_req_reg         <= 1'b0;
        end else begin
            rx_active_reg <= rx_active_next;
            rx_req_reg    <= !rx_dma_request_n_o;
            if (dma1_eff) begin
                rx_dma_request_n_o <= !rx_active_next;
            end else begin
                rx_dma_request_n_o <= rxf.empty;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupts: sticky, write one to clear, a new event wins
    assign status_set[UFC_IRQ_TXSPACE] = tx_level_ok && !tx_level_reg
                                         && thr_en;
    assign status_set[UFC_IRQ_RXREQ]   = !rx_dma_request_n_o && !rx_req_reg;
    assign status_set[UFC_IRQ_RXOVR]   = rxf.push && rxf.full;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_reg <= '0;
        end else if (wr && idx == UFC_IDX_STATUS && wb_sel_i[0]) begin
            status_reg <= (status_reg & ~wb_dat_i[UFC_IRQ_W-1:0])
                          | status_set;
        end else begin
            status_reg <= status_reg | status_set;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_reg <= '0;
        end else if (wr && idx == UFC_IDX_MASK && wb_sel_i[0]) begin
            mask_reg <= wb_dat_i[UFC_IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(status_reg & mask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux; the control register reads zero at its own index, its value shows in the state word
    always_comb begin
        rd_value = 32'h0000_0000;
        unique case (idx)
            UFC_IDX_DATA:   rd_value = {24'h00_0000, rxf.rdata};
            UFC_IDX_STATUS: rd_value = 32'(status_reg);
            UFC_IDX_MASK:   rd_value = 32'(mask_reg);
            UFC_IDX_STATE:  rd_value = {8'h00, 8'(rxf.count),
                                        8'(txf.count), fifo_control_reg};
            default:        rd_value = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= taken;
            if (rd) begin
                wb_dat_o <= rd_value;
            end
        end
    end

    assign tx_shift_data_o  = tx_shift_reg;
    assign tx_shift_valid_o = tx_shift_full_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks
    fcr_reset_a: assert property (@(posedge clk_i)
        rst_i |=> fifo_control_reg == UFC_FCR_RESET && !dma1_eff)
        else $error("control not default after reset");
    fcr_guard_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr && idx == UFC_IDX_FCR && wb_sel_i[0]
            && !wb_dat_i[UFC_FCR_EN])
        |=> fifo_control_reg[7:1] == $past(fifo_control_reg[7:1])
            && !fifo_en)
        else $error("control bits changed with bit 0 clear");
    thr_reserved_a: assert property (@(posedge clk_i)
        HAS_THR || fifo_control_reg[5:4] == 2'b00)
        else $error("reserved threshold bits stored");
    tx_clear_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        tx_clr |=> txf.count == '0 && tx_shift_valid_o
            == $past(tx_shift_full_reg && !tx_shift_done_i))
        else $error("transmit fifo not emptied");
    tx_shift_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (tx_clr && !tx_shift_done_i) |=> $stable(tx_shift_reg))
        else $error("transmit shift register disturbed by clear");
    rx_shift_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (rx_clr && !rx_char_valid_i)
        |=> $stable(rx_shift_reg) && $stable(rx_shift_full_reg))
        else $error("receive shift register disturbed by clear");
    rx_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !dma1_eff |=> rx_dma_request_n_o == $past(rxf.empty))
        else $error("single mode receive request wrong");
    tx_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!dma1_eff && txf.empty) |=> !tx_dma_request_n_o)
        else $error("single mode transmit request missing");
    tx_block_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (dma1_eff && tx_active_reg && !txf.full)
        |=> !tx_dma_request_n_o)
        else $error("block mode transmit request dropped early");
    rx_block_end_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (dma1_eff && rxf.empty) |=> rx_dma_request_n_o)
        else $error("block mode receive request held while empty");
    tx_space_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (thr_en && tx_level_ok && !tx_level_reg)
        |=> status_reg[UFC_IRQ_TXSPACE])
        else $error("transmit space event not recorded");
endmodule
`default_nettype wire

// File: verification/ufc_line_model.sv
// Purpose: serializer and receiver stand-in at the far side of the block
// Assumes: one clock; the bench steers drain, send and timeout
// Notes:   rx byte inverts outside its strobe so stale data never looks valid
`default_nettype none
module ufc_line_model (
    input  wire logic       clk_i,      // system clock
    input  wire logic       drain_i,    // serializer running
    input  wire logic       tx_valid_i, // shift register loaded
    input  wire logic       send_i,     // deliver one character
    input  wire logic [7:0] byte_i,     // character to deliver
    input  wire logic       tmo_i,      // timeout request
    output var  logic       done_o     = 1'b0,  // byte consumed
    output var  logic       rx_valid_o = 1'b0,  // character strobe
    output var  logic [7:0] rx_char_o  = 8'h00, // character
    output var  logic       rx_tmo_o   = 1'b0   // timeout pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    // a slow serializer: at most one byte every other cycle
    always_ff @(posedge clk_i) begin
        done_o <= drain_i & tx_valid_i & ~done_o;
    end
    always_ff @(posedge clk_i) begin
        rx_valid_o <= send_i;
        rx_char_o  <= send_i ? byte_i : ~rx_char_o;
        rx_tmo_o   <= tmo_i;
    end
endmodule
`default_nettype wire

// File: verification/testbench.sv
// Purpose: self-checking bench of the uart fifo control block
// Assumes: 64-byte build, classic wishbone master driven on rising edges
// Notes:   the 16-byte build is not exercised here
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import ufc_pkg::*;
    localparam logic [7:0] A_DATA  = {UFC_IDX_DATA, 2'b00};
    localparam logic [7:0] A_FCR   = {UFC_IDX_FCR, 2'b00};
    localparam logic [7:0] A_STAT  = {UFC_IDX_STATUS, 2'b00};
    localparam logic [7:0] A_MASK  = {UFC_IDX_MASK, 2'b00};
    localparam logic [7:0] A_STATE = {UFC_IDX_STATE, 2'b00};
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0;
    logic        we = 1'b0, drain = 1'b0, send = 1'b0, tmo = 1'b0;
    logic [7:0]  adr = 8'h00, sbyte = 8'h00, tx_data, rx_char;
    logic [31:0] dat = 32'h0, rdat, q;
    logic        ack, done, tx_valid, rx_valid, rx_tmo, tx_rq_n, rx_rq_n, irq;
    int          miscompares = 0;
    int          comparisons = 0;
    ufc_top #(.DEPTH(64)) ufc_top_inst (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .tx_shift_done_i(done), .tx_shift_data_o(tx_data),
        .tx_shift_valid_o(tx_valid), .rx_char_valid_i(rx_valid),
        .rx_char_i(rx_char), .rx_timeout_i(rx_tmo),
        .rx_trigger_level_i(7'h02), .tx_dma_request_n_o(tx_rq_n),
        .rx_dma_request_n_o(rx_rq_n), .irq_o(irq));
    ufc_line_model ufc_line_model_inst (.clk_i(clk_i), .drain_i(drain),
        .tx_valid_i(tx_valid), .send_i(send), .byte_i(sbyte), .tmo_i(tmo),
        .done_o(done), .rx_valid_o(rx_valid), .rx_char_o(rx_char),
        .rx_tmo_o(rx_tmo));
    initial forever #5 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    // classic cycle: hold everything until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic send_char(input logic [7:0] c);
        @(posedge clk_i);
        send  <= 1'b1;
        sbyte <= c;
        @(posedge clk_i);
        send <= 1'b0;
        settle(4);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        settle(1);
        chk("tx_rq_n", 0, tx_rq_n);
        chk("rx_rq_n", 1, rx_rq_n);
        chk("irq", 0, irq);
        wb(1'b0, A_STATE, 32'h0);
        chk("state", 32'h0, q);
        wb(1'b0, A_FCR, 32'h0);
        chk("fcr_read", 32'h0, q);
        wb(1'b1, A_FCR, 32'h3e);
        wb(1'b0, A_STATE, 32'h0);
        chk("fcr_no_en", 8'h00, q[7:0]);
        wb(1'b1, A_FCR, 32'h01);
        wb(1'b0, A_STATE, 32'h0);
        chk("fcr_en", 8'h01, q[7:0]);
    endtask
    task automatic t_tx_clear();
        wb(1'b1, A_DATA, 32'ha1);
        wb(1'b1, A_DATA, 32'ha2);
        wb(1'b1, A_DATA, 32'ha3);
        settle(4);
        chk("tx_rq_n", 1, tx_rq_n);
        wb(1'b0, A_STATE, 32'h0);
        chk("tx_count", 8'h02, q[15:8]);
        wb(1'b1, A_FCR, 32'h05);
        settle(2);
        wb(1'b0, A_STATE, 32'h0);
        chk("tx_cleared", 16'h0001, q[15:0]);
        chk("tx_shift", 9'h1a1, {tx_valid, tx_data});
    endtask
    task automatic t_rx();
        wb(1'b1, A_FCR, 32'h09);
        send_char(8'h5c);
        chk("rx_rq_n", 1, rx_rq_n);
        send_char(8'hc5);
        chk("rx_rq_n", 0, rx_rq_n);
        wb(1'b0, A_DATA, 32'h0);
        chk("rx_pop", 8'h5c, q[7:0]);
        wb(1'b1, A_FCR, 32'h0b);
        settle(2);
        chk("rx_rq_n", 1, rx_rq_n);
        wb(1'b0, A_STATE, 32'h0);
        chk("rx_cleared", 8'h00, q[23:16]);
        chk("fcr_self", 8'h09, q[7:0]);
        wb(1'b1, A_FCR, 32'h01);
        send_char(8'h3a);
        chk("rx_rq_n", 0, rx_rq_n);
        wb(1'b0, A_DATA, 32'h0);
        chk("rx_pop_single", 8'h3a, q[7:0]);
        settle(2);
        chk("rx_rq_n", 1, rx_rq_n);
        wb(1'b1, A_FCR, 32'h09);
        send_char(8'h77);
        @(posedge clk_i);
        tmo <= 1'b1;
        @(posedge clk_i);
        tmo <= 1'b0;
        settle(3);
        chk("rx_rq_tmo", 0, rx_rq_n);
    endtask
    task automatic t_threshold();
        int n;
        wb(1'b1, A_MASK, 32'h01);
        wb(1'b1, A_FCR, 32'h39);
        for (n = 0; n < 64; n++) wb(1'b1, A_DATA, n);
        settle(3);
        chk("tx_rq_full", 1, tx_rq_n);
        wb(1'b0, A_STATE, 32'h0);
        chk("state", 16'h4039, q[15:0]);
        wb(1'b1, A_STAT, 32'h07);
        settle(3);
        chk("irq_clr", 0, irq);
        @(posedge clk_i);
        drain <= 1'b1;
        n = 0;
        while (tx_rq_n !== 1'b0 && n < 900) begin
            @(negedge clk_i);
            n++;
        end
        chk("tx_rq_space", 0, tx_rq_n);
        @(posedge clk_i);
        drain <= 1'b0;
        wb(1'b0, A_STATE, 32'h0);
        chk("space_gt_56", 1, q[15:8] < 8'h08);
        settle(2);
        chk("irq_set", 1, irq);
        wb(1'b1, A_STAT, 32'h01);
        settle(3);
        chk("irq_w1c", 0, irq);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_tx_clear();
        t_rx();
        t_threshold();
        results();
    end
    initial begin
        #200000;
        miscompares++;
        results();
    end
endmodule
`default_nettype wire
